// ### verilog/cjpc_pkg.sv
package cjpc_pkg;

  // core clock rate
  localparam real CLK_MHZ        = 10.0;
  // least low width of the reconfiguration request, in us
  localparam real RECONF_MIN_US  = 0.32;
  localparam int  RECONF_MIN_CYC = ($ceil(RECONF_MIN_US * CLK_MHZ) < 1.0) ? 1 :
                                   int'($ceil(RECONF_MIN_US * CLK_MHZ));
  // least delay from done high to user mode, in us
  localparam real USER_MIN_US    = 25.0;
  localparam int  USER_MIN_CYC   = ($ceil(USER_MIN_US * CLK_MHZ) < 1.0) ? 1 :
                                   int'($ceil(USER_MIN_US * CLK_MHZ));

  // counter widths
  localparam int CNT_W  = 13;
  localparam int RLOW_W = 4;
  localparam logic [CNT_W-1:0]  USER_MIN_CNT   = CNT_W'(USER_MIN_CYC - 1);
  localparam logic [RLOW_W-1:0] RECONF_MIN_CNT = RLOW_W'(RECONF_MIN_CYC);

  // synchronised pin lanes
  localparam int PIN_N    = 5;
  localparam int PIN_TCK  = 0;
  localparam int PIN_TMS  = 1;
  localparam int PIN_TDI  = 2;
  localparam int PIN_RCF  = 3;
  localparam int PIN_DONE = 4;
  localparam logic [PIN_N-1:0] PIN_RST = 5'h1F;

  // instruction and data register layout
  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam logic [IR_W-1:0] IR_CAPTURE  = 4'h1;
  localparam logic [IR_W-1:0] INS_IDCODE  = 4'h2;
  localparam logic [IR_W-1:0] INS_BYPASS  = 4'hF;
  localparam logic [ID_W-1:0] DR_ZERO     = 32'h0000_0000;

  // test controller states
  typedef enum logic [3:0] {
    TAP_RESET  = 4'hF, TAP_IDLE   = 4'hC, TAP_SEL_DR = 4'h7, TAP_CAP_DR = 4'h6,
    TAP_SH_DR  = 4'h2, TAP_EX1_DR = 4'h1, TAP_PA_DR  = 4'h3, TAP_EX2_DR = 4'h0,
    TAP_UPD_DR = 4'h5, TAP_SEL_IR = 4'h4, TAP_CAP_IR = 4'hE, TAP_SH_IR  = 4'hA,
    TAP_EX1_IR = 4'h9, TAP_PA_IR  = 4'hB, TAP_EX2_IR = 4'h8, TAP_UPD_IR = 4'hD
  } cjpc_tap_t;

  // configuration sequencer states
  typedef enum logic [1:0] {
    CFG_LOAD = 2'h0,
    CFG_WAIT = 2'h1,
    CFG_USER = 2'h3
  } cjpc_cfg_t;

endpackage

// ### verilog/cjpc_top.sv
`timescale 1ns/1ps
module cjpc_top #(
  parameter int unsigned                 CFG_LOAD_CYC = 64,          // bitstream load length in cycles
  parameter logic [cjpc_pkg::ID_W-1:0]   ID_VALUE     = 32'h0000_0001 // arbitrary identity value
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic reconfig_req_n,
  input  wire logic config_done_flag_pin,
  output logic      config_done_flag_dat,
  output logic      config_done_flag_oe,
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  output logic      tms_pu_en,
  output logic      tdi_pu_en,
  output logic      tdo,
  output logic      tdo_oe,
  output logic      cfg_busy,
  output logic      user_mode,
  output logic      sys_rst_n
);
  import cjpc_pkg::*;

  // load length as a counter compare value
  localparam logic [CNT_W-1:0] LOAD_CNT = CNT_W'(CFG_LOAD_CYC - 1);

  // reset release
  // reset asserts at once and lifts two core_clk edges later
  logic rst_s1_q;  // first release stage
  logic rst_n_q;   // released reset used everywhere

  // two-stage release so reset removal is clean to core_clk
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // pin sampling
  // every pin is outside this clock domain, so each passes three stages
  logic [PIN_N-1:0] pin_raw;   // pins gathered into lanes
  logic [PIN_N-1:0] s1_q;      // first stage, read only by s2
  logic [PIN_N-1:0] s2_q;      // second stage
  logic [PIN_N-1:0] s3_q;      // third stage
  logic [PIN_N-1:0] lvl_q;     // accepted level per lane
  logic [PIN_N-1:0] lvl_d;

  // lane order matches the pin lane positions of the package
  assign pin_raw = {config_done_flag_pin, reconfig_req_n, tdi, tms, tck};

  // a lane moves only once stages two and three agree
  // holding the old level while they differ filters a one-cycle glitch
  always_comb begin
    lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
  end

  // pins idle high, so reset the chain to ones
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s1_q  <= PIN_RST;
      s2_q  <= PIN_RST;
      s3_q  <= PIN_RST;
      lvl_q <= PIN_RST;
    end else begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // weak pull-ups stay on: an undriven pin reads as one
  assign tms_pu_en = 1'b1;
  assign tdi_pu_en = 1'b1;

  // test clock edges
  // the test clock is only sampled; its edges become one-cycle pulses
  // limitation: each test clock phase must last several core_clk cycles
  logic tck_prev_q;  // last accepted test clock
  logic tck_rise;    // one-cycle pulse on test clock rise
  logic tck_fall;    // one-cycle pulse on test clock fall
  logic tms_s;       // accepted mode-select
  logic tdi_s;       // accepted serial data

  assign tck_rise = lvl_q[PIN_TCK] & ~tck_prev_q;
  assign tck_fall = ~lvl_q[PIN_TCK] & tck_prev_q;
  assign tms_s    = lvl_q[PIN_TMS];
  assign tdi_s    = lvl_q[PIN_TDI];

  // test controller
  // state and registers move only on the edge pulses, never on core_clk alone
  cjpc_tap_t         tap_q, tap_d;      // controller state
  logic [IR_W-1:0]   ir_q, ir_d;        // active instruction
  logic [IR_W-1:0]   irs_q, irs_d;      // instruction shift stage
  logic [ID_W-1:0]   drs_q, drs_d;      // data shift stage
  logic              tdo_q, tdo_d;      // serial output bit
  logic              tdoe_q, tdoe_d;    // serial output enable
  logic              sel_id;            // identity register selected

  // any instruction other than identity falls back to the one-bit path
  assign sel_id = (ir_q == INS_IDCODE);

  // next controller values; state and shifts move on rise, output on fall
  always_comb begin
    tap_d  = tap_q;
    ir_d   = ir_q;
    irs_d  = irs_q;
    drs_d  = drs_q;
    tdo_d  = tdo_q;
    tdoe_d = tdoe_q;
    if (tck_rise) begin
      // standard step on the sampled mode-select
      case (tap_q)
        TAP_RESET:  tap_d = tms_s ? TAP_RESET  : TAP_IDLE;
        TAP_IDLE:   tap_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
        // data column
        TAP_SEL_DR: tap_d = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: tap_d = tms_s ? TAP_EX1_DR : TAP_SH_DR;
        TAP_SH_DR:  tap_d = tms_s ? TAP_EX1_DR : TAP_SH_DR;
        TAP_EX1_DR: tap_d = tms_s ? TAP_UPD_DR : TAP_PA_DR;
        TAP_PA_DR:  tap_d = tms_s ? TAP_EX2_DR : TAP_PA_DR;
        TAP_EX2_DR: tap_d = tms_s ? TAP_UPD_DR : TAP_SH_DR;
        TAP_UPD_DR: tap_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
        // instruction column
        TAP_SEL_IR: tap_d = tms_s ? TAP_RESET  : TAP_CAP_IR;
        TAP_CAP_IR: tap_d = tms_s ? TAP_EX1_IR : TAP_SH_IR;
        TAP_SH_IR:  tap_d = tms_s ? TAP_EX1_IR : TAP_SH_IR;
        TAP_EX1_IR: tap_d = tms_s ? TAP_UPD_IR : TAP_PA_IR;
        TAP_PA_IR:  tap_d = tms_s ? TAP_EX2_IR : TAP_PA_IR;
        TAP_EX2_IR: tap_d = tms_s ? TAP_UPD_IR : TAP_SH_IR;
        TAP_UPD_IR: tap_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
        // escape from an illegal code
        default:    tap_d = TAP_RESET;
      endcase
      // register actions in the state being left
      case (tap_q)
        TAP_RESET:  ir_d  = INS_IDCODE;
        // fixed capture pattern lets a host check the path
        TAP_CAP_IR: irs_d = IR_CAPTURE;
        TAP_SH_IR:  irs_d = {tdi_s, irs_q[IR_W-1:1]};
        // identity value or the bypass zero
        TAP_CAP_DR: drs_d = sel_id ? ID_VALUE : DR_ZERO;
        TAP_SH_DR: begin
          // path length follows the selected register
          if (sel_id) begin
            drs_d = {tdi_s, drs_q[ID_W-1:1]};
          end else begin
            drs_d = {drs_q[ID_W-1:1], tdi_s};
          end
        end
        default: begin
          // no register action in other states
        end
      endcase
    end
    if (tck_fall) begin
      // instruction takes effect on fall in update, as the real port does
      if (tap_q == TAP_UPD_IR) begin
        ir_d = irs_q;
      end
      // output follows the shift stage of the path in use
      tdo_d  = (tap_q == TAP_SH_IR) ? irs_q[0] : drs_q[0];
      // enabled only while a shift state is current
      tdoe_d = (tap_q == TAP_SH_IR) || (tap_q == TAP_SH_DR);
    end
  end

  // controller state only; config restart never touches it
  // the test clock copy starts high, so no false fall follows reset
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tap_q      <= TAP_RESET;
      ir_q       <= INS_IDCODE;
      irs_q      <= IR_CAPTURE;
      drs_q      <= DR_ZERO;
      tdo_q      <= 1'b0;
      tdoe_q     <= 1'b0;
      tck_prev_q <= 1'b1;
    end else begin
      tap_q      <= tap_d;
      ir_q       <= ir_d;
      irs_q      <= irs_d;
      drs_q      <= drs_d;
      tdo_q      <= tdo_d;
      tdoe_q     <= tdoe_d;
      tck_prev_q <= lvl_q[PIN_TCK];
    end
  end

  // disabled output still takes the shift stage bit on each fall; the pad floats it
  // the pad turns a low enable into high impedance
  assign tdo    = tdo_q;
  assign tdo_oe = tdoe_q;

  // configuration sequencer
  // load, wait for the wire to go high, then count the user-entry delay
  cjpc_cfg_t          cfg_q, cfg_d;      // sequencer state
  logic [CNT_W-1:0]   cnt_q, cnt_d;      // load or user-entry count
  logic [RLOW_W-1:0]  rlow_q, rlow_d;    // request low width, saturating
  logic               rcf_prev_q;        // last accepted request level
  logic               oe_q, oe_d;        // done flag pull-down
  logic               user_q, user_d;    // user mode reached
  logic               rcf_rise;          // request released
  logic               restart;           // valid reconfiguration request
  logic               done_hi;           // done flag seen high on the wire

  // a request edge only counts after a long enough low
  assign rcf_rise = lvl_q[PIN_RCF] & ~rcf_prev_q;
  assign restart  = rcf_rise && (rlow_q >= RECONF_MIN_CNT);
  assign done_hi  = lvl_q[PIN_DONE];

  // next sequencer values
  always_comb begin
    cfg_d  = cfg_q;
    cnt_d  = cnt_q;
    rlow_d = rlow_q;
    // measure the low pulse; a short one is ignored
    if (!lvl_q[PIN_RCF]) begin
      if (rlow_q < RECONF_MIN_CNT) begin
        rlow_d = rlow_q + RLOW_W'(1);
      end
    end else begin
      rlow_d = '0;
    end
    case (cfg_q)
      CFG_LOAD: begin
        // bitstream load, flag held low
        if (cnt_q >= LOAD_CNT) begin
          cfg_d = CFG_WAIT;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      CFG_WAIT: begin
        // an outside party holding the flag low keeps us here
        if (!done_hi) begin
          cnt_d = '0;
        end else if (cnt_q >= USER_MIN_CNT) begin
          cfg_d = CFG_USER;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      CFG_USER: begin
        // flag dragged low again leaves user mode
        if (!done_hi) begin
          cfg_d = CFG_WAIT;
          cnt_d = '0;
        end
      end
      // unused code falls back to a fresh load
      default: begin
        cfg_d = CFG_LOAD;
        cnt_d = '0;
      end
    endcase
    // rising edge of the request restarts loading only
    if (restart) begin
      cfg_d = CFG_LOAD;
      cnt_d = '0;
    end
    // pull low until loaded, then let the resistor take it high
    oe_d   = (cfg_d == CFG_LOAD);
    user_d = (cfg_d == CFG_USER);
  end

  // sequencer registers; configuration begins out of reset
  // the request copy starts high, matching the idle pin
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q      <= CFG_LOAD;
      cnt_q      <= '0;
      rlow_q     <= '0;
      rcf_prev_q <= 1'b1;
      oe_q       <= 1'b1;
      user_q     <= 1'b0;
    end else begin
      cfg_q      <= cfg_d;
      cnt_q      <= cnt_d;
      rlow_q     <= rlow_d;
      rcf_prev_q <= lvl_q[PIN_RCF];
      oe_q       <= oe_d;
      user_q     <= user_d;
    end
  end

  // open drain: only ever drives zero
  assign config_done_flag_dat = 1'b0;
  assign config_done_flag_oe  = oe_q;
  // these pins carry no general-purpose path at any time
  // busy mirrors the pull-down, high for the whole load
  assign cfg_busy             = oe_q;
  assign user_mode            = user_q;
  // system side held in reset until user entry delay is over
  assign sys_rst_n            = user_q;

endmodule

// ### bench/cjpc_chk.sv
`timescale 1ns/1ps
module cjpc_chk import cjpc_pkg::*; #(
  parameter int unsigned CFG_LOAD_CYC = 64
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic reconfig_req_n,
  input wire logic config_done_flag_pin,
  input wire logic config_done_flag_dat,
  input wire logic config_done_flag_oe,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic cfg_busy,
  input wire logic user_mode,
  input wire logic sys_rst_n
);
  logic        tck_q, req_q;                // previous pin samples
  logic [3:0]  fall_q, fall_d, rise_q, rise_d; // age of tck fall, request rise
  logic [15:0] oe_q, oe_d, hi_q, hi_d;       // done drive run, done high run
  // saturating ages, so stale edges never wrap into a window
  always_comb begin
    fall_d = (tck_q && !tck) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hF};
    rise_d = (!req_q && reconfig_req_n) ? 4'h0 : rise_q + {3'h0, rise_q != 4'hF};
    oe_d   = config_done_flag_oe ? oe_q + {15'h0, oe_q != 16'hFFFF} : 16'h0000;
    hi_d   = config_done_flag_pin ? hi_q + {15'h0, hi_q != 16'hFFFF} : 16'h0000;
  end
  // register the helpers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {tck_q, req_q} <= 2'h3;
      {fall_q, rise_q} <= 8'hFF;
      {oe_q, hi_q} <= 32'h0000_0000;
    end else begin
      {tck_q, req_q} <= {tck, reconfig_req_n};
      {fall_q, rise_q} <= {fall_d, rise_d};
      {oe_q, hi_q} <= {oe_d, hi_d};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  dat_low_a: assert property (config_done_flag_dat == 1'b0) else $error("done drive not low");
  user_block_a: assert property (!config_done_flag_pin [*8] |-> !user_mode) else $error("user while low");
  rst_follow_a: assert property (sys_rst_n == user_mode) else $error("system reset mismatch");
  busy_follow_a: assert property (cfg_busy == config_done_flag_oe) else $error("busy mismatch");
  tdo_fall_a: assert property ($changed(tdo) |-> fall_q inside {[1:6]}) else $error("tdo off fall");
  oe_fall_a: assert property ($changed(tdo_oe) |-> fall_q inside {[1:6]}) else $error("oe off fall");
  reconf_edge_a: assert property ($rose(config_done_flag_oe) |-> rise_q <= 4'h8) else $error("load no edge");
  load_len_a: assert property ($fell(config_done_flag_oe) |-> oe_q >= CFG_LOAD_CYC - 1) else $error("load short");
  user_wait_a: assert property ($rose(user_mode) |-> hi_q >= USER_MIN_CYC) else $error("user too soon");
  cover property ($rose(user_mode));
  cover property ($rose(tdo_oe));
  cover property ($rose(config_done_flag_oe));
endmodule
bind cjpc_top cjpc_chk #(.CFG_LOAD_CYC(CFG_LOAD_CYC)) u_chk (.core_clk(core_clk), .nrst(nrst),
  .reconfig_req_n(reconfig_req_n), .config_done_flag_pin(config_done_flag_pin),
  .config_done_flag_dat(config_done_flag_dat), .config_done_flag_oe(config_done_flag_oe), .tck(tck),
  .tdo(tdo), .tdo_oe(tdo_oe), .cfg_busy(cfg_busy), .user_mode(user_mode), .sys_rst_n(sys_rst_n));

// ### bench/cjpc_host.sv
`timescale 1ns/1ps
module cjpc_host (
  input  wire logic core_clk,
  input  wire logic done_oe,
  input  wire logic hold_low,
  input  wire logic tms_pu_en,
  input  wire logic tdi_pu_en,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      done_pin
);
  logic drv_q, tms_q, tdi_q; // host drive state
  // link clock parked high between frames
  initial begin
    tck   = 1'b1;
    drv_q = 1'b0;
    tms_q = 1'b1;
    tdi_q = 1'b1;
  end
  // open drain: either party pulls low, else pull-up
  assign done_pin = (done_oe || hold_low) ? 1'b0 : 1'b1;
  // released lines read through the pull-ups, else drift
  assign tms = drv_q ? tms_q : (tms_pu_en ? 1'b1 : ~tms_q);
  assign tdi = drv_q ? tdi_q : (tdi_pu_en ? 1'b1 : ~tdi_q);
  // one tck period of eight core cycles
  task automatic step(input logic en, input logic m, input logic d, output logic o);
    @(posedge core_clk) tck <= 1'b0;
    @(posedge core_clk) drv_q <= en;
    tms_q <= m;
    tdi_q <= d;
    repeat (3) @(posedge core_clk);
    tck <= 1'b1;
    repeat (3) @(posedge core_clk);
    o = tdo;
  endtask
endmodule

// ### bench/config_jtag_pin_control_bench.sv
`timescale 1ns/1ps
module config_jtag_pin_control_bench import cjpc_pkg::*;;
  localparam int unsigned     LOAD = 8;
  localparam logic [ID_W-1:0] ID   = 32'h5A3C_9617; // arbitrary identity value
  logic core_clk, nrst, reconfig_req_n, hold_low;
  logic tck, tms, tdi, done_pin, dat, done_oe, tms_pu, tdi_pu, tdo, tdo_oe, busy, user_mode, sys_rst_n;
  int   fails, total_checks;
  always #50 core_clk = ~core_clk;
  cjpc_top #(.CFG_LOAD_CYC(LOAD), .ID_VALUE(ID)) u_dut (.core_clk(core_clk), .nrst(nrst),
    .reconfig_req_n(reconfig_req_n), .config_done_flag_pin(done_pin), .config_done_flag_dat(dat),
    .config_done_flag_oe(done_oe), .tck(tck), .tms(tms), .tdi(tdi), .tms_pu_en(tms_pu), .tdi_pu_en(tdi_pu),
    .tdo(tdo), .tdo_oe(tdo_oe), .cfg_busy(busy), .user_mode(user_mode), .sys_rst_n(sys_rst_n));
  cjpc_host u_host (.core_clk(core_clk), .done_oe(done_oe), .hold_low(hold_low), .tms_pu_en(tms_pu),
    .tdi_pu_en(tdi_pu), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .done_pin(done_pin));
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // bounded wait for user mode, cycles counted
  task automatic wait_user(output int c);
    c = 0;
    while (user_mode !== 1'b1 && c < 3000) begin
      @(posedge core_clk);
      c++;
    end
  endtask
  // idle -> capture -> shift n bits lsb first -> update -> idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] q, output logic oe);
    logic o;
    q  = 64'h0;
    oe = 1'b1;
    u_host.step(1'b1, 1'b1, 1'b0, o);
    if (ir) u_host.step(1'b1, 1'b1, 1'b0, o);
    u_host.step(1'b1, 1'b0, 1'b0, o);
    u_host.step(1'b1, 1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      u_host.step(1'b1, i == n - 1, din[i], o);
      q[i] = o;
      oe   = oe & tdo_oe;
    end
    u_host.step(1'b1, 1'b1, 1'b0, o);
    u_host.step(1'b1, 1'b0, 1'b0, o);
  endtask
  task automatic t_boot();
    int c;
    chk("done driven low", {done_oe, done_pin}, 2'h2);
    chk("busy drive", {busy, dat}, 2'h2);
    wait_user(c);
    chk("user entered", user_mode, 1'b1);
    chk("entry delay", c >= LOAD + USER_MIN_CYC, 1'b1);
    $display("boot done");
  endtask
  task automatic t_bypass();
    logic [63:0] q;
    logic        oe;
    logic        o;
    // controller sits in test-logic reset after boot: step to idle first
    u_host.step(1'b1, 1'b0, 1'b0, o);
    scan(1'b1, 4, 64'hF, q, oe);
    chk("ir capture", q[3:0], 4'h1);
    scan(1'b0, 8, 64'hB5, q, oe);
    chk("bypass delay", q[7:0], 8'h6A);
    $display("bypass done");
  endtask
  task automatic t_idcode();
    logic [63:0] q;
    logic        oe;
    logic        o;
    for (int i = 0; i < 5; i++) u_host.step(1'b0, 1'b0, 1'b0, o);
    u_host.step(1'b1, 1'b0, 1'b0, o);
    chk("pull-ups on", {tms_pu, tdi_pu}, 2'h3);
    scan(1'b0, 64, {32'h0, 32'hC0DE_F00D}, q, oe);
    chk("idcode out", q[31:0], ID);
    chk("shift delay", q[63:32], 32'hC0DE_F00D);
    chk("oe shifting", oe, 1'b1);
    chk("oe idle", tdo_oe, 1'b0);
    $display("idcode done");
  endtask
  task automatic t_reconf();
    logic [63:0] q;
    logic        oe;
    int          c;
    @(posedge core_clk) reconfig_req_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reconfig_req_n <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk("short pulse", done_oe, 1'b0);
    reconfig_req_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("low alone", done_oe, 1'b0);
    reconfig_req_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("reload", {done_oe, user_mode}, 2'h2);
    wait_user(c);
    chk("user again", user_mode, 1'b1);
    scan(1'b0, 32, 64'h0, q, oe);
    chk("tap kept", q[31:0], ID);
    $display("reconf done");
  endtask
  task automatic t_hold();
    int c;
    @(posedge core_clk) hold_low <= 1'b1;
    repeat (400) @(posedge core_clk);
    chk("held low", {user_mode, sys_rst_n}, 2'h0);
    hold_low <= 1'b0;
    wait_user(c);
    chk("entry after hold", {user_mode, c >= USER_MIN_CYC}, 2'h3);
    $display("hold done");
  endtask
  initial begin
    core_clk       = 1'b0;
    nrst           = 1'b0;
    reconfig_req_n = 1'b1;
    hold_low       = 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_boot();
    t_bypass();
    t_idcode();
    t_reconf();
    t_hold();
    results();
  end
  // hang guard, several times the expected run
  initial begin
    #1000000;
    fails++;
    results();
  end
endmodule
